// ### core/vme_int_regs.vh
`ifndef VME_INT_REGS_VH
`define VME_INT_REGS_VH
// Register byte offsets on the AXI4-Lite slave.
`define OFF_LOCAL_ENABLE    8'h00
`define OFF_LOCAL_STATUS    8'h04
`define OFF_LOCAL_MAP_LOW   8'h08
`define OFF_LOCAL_MAP_HIGH  8'h0c
`define OFF_VME_ENABLE      8'h10
`define OFF_VME_STATUS      8'h14
`define OFF_VME_MAP_LOW     8'h18
`define OFF_VME_MAP_HIGH    8'h1c
`define OFF_VECTOR_VALUE    8'h20
`define OFF_CONTROL         8'h24
`define OFF_CAPTURE_FIRST   8'h28
`define OFF_CAPTURE_LAST    8'h40
// Reset values.
`define RST_ENABLE          16'h0000
`define RST_MAP             24'h000000
`define RST_VECTOR          7'h00
// Local-side source bit positions; vme levels 1..7 sit at 8..14.
`define LSRC_ACFAIL         0
`define LSRC_SYSFAIL        1
`define LSRC_SOFT           2
`define LSRC_SOFT_ACK       3
`define LSRC_VME_FAULT      4
`define LSRC_LOCAL_FAULT    5
`define LSRC_DMA            6
`define LSRC_OWNERSHIP      7
`define LSRC_LEVEL_BASE     8
// Vme-side source bit positions; local lines 7..0 sit at 7..0.
`define VSRC_DMA            8
`define VSRC_VME_FAULT      9
`define VSRC_LOCAL_FAULT    10
`define VSRC_SOFT           11
// Control register fields.
`define CTL_LOCAL_SOFT      0
`define CTL_VME_SOFT        1
`define CTL_OWN_REQ         2
// Capture register error flag position.
`define CAP_ERR_BIT         8
// Handler state machine codes.
`define ST_IDLE             1'b0
`define ST_ACK              1'b1
// AXI responses.
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

// ### core/vme_pci_interrupt_channel.v
// Function
// - Software source wins over hardware source sharing one vme level.
// - Vme-bound sources drive seven active-low request outputs, levels 7..1.
// - Each raised vme interrupt answers its IACK with an 8-bit vector.
// - Software vme request clears on acknowledge; others clear by register write.
// - Enabled incoming vme level runs an IACK cycle and keeps the vector.
// - Local lines route only to vme, vme levels only to local outputs.
// - Every source has its own enable bit.
// - Enabled local source sets status and drives its mapped local output.
// - Local sources: fail lines, levels, dma, faults, soft, soft ack, ownership.
// - Local status shows pending sources whether enabled or not, except vme levels, which set status only when enabled.
// - Fail lines set status by level; output drops after level and clear.
// - Fail inputs are synchronized and glitch-filtered on the core clock.
// - Other local sources are edge events; levels fire on vector capture.
// - Latched local status and output hold until software writes one.
// - Vme sources have enable bits and level maps across two registers.
// - Sources may share levels; a level 0 map asserts nothing.
// - Firing vme source sets status; if enabled, asserts its mapped level.
// - Vector is returned only for our level with daisy-chain input asserted.
// - Vector upper seven bits programmable; bit 0 low only for software.
// - Writing one to a vme status bit clears it and releases the output.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "vme_int_regs.vh"
module vme_pci_interrupt_channel (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  local_int_line,
  input  wire [7:1]  vme_irq_in_n,
  input  wire        acfail_n,
  input  wire        sysfail_n,
  input  wire        dma_event,
  input  wire        vme_fault_event,
  input  wire        local_fault_event,
  input  wire        bus_ownership_granted,
  output wire        bus_ownership_request,
  output reg  [7:0]  local_int_out,
  output reg  [7:1]  vme_irq_out_n,
  input  wire        iack_strobe,
  input  wire [2:0]  iack_level,
  input  wire        iackin_asserted,
  output reg         iack_hit,
  output reg         iack_pass,
  output reg  [7:0]  iack_vector,
  output reg         iack_master_req,
  output reg  [2:0]  iack_master_level,
  input  wire        iack_master_done,
  input  wire [7:0]  iack_master_vector,
  input  wire        iack_master_err
);

  // Three-bit select to one-hot decode, shared by both routing directions.
  function [7:0] onehot3;
    input [2:0] sel;
    begin
      onehot3 = 8'h01 << sel;
    end
  endfunction

  reg  [15:0] local_side_enable;
  reg  [15:0] local_side_status;
  reg  [23:0] local_side_map_low;
  reg  [23:0] local_side_map_high;
  reg  [11:0] vme_side_enable;
  reg  [11:0] vme_side_status;
  reg  [23:0] vme_side_map_low;
  reg  [11:0] vme_side_map_high;
  reg  [7:1]  vector_value_reg;
  reg         own_req;
  reg  [8:0]  cap_vec [1:7];
  reg  [7:0]  line_s1;
  reg  [7:0]  line_s2;
  reg  [7:1]  irq_s1;
  reg  [7:1]  irq_s2;
  reg  [1:0]  fail_s1;
  reg  [1:0]  fail_s2;
  reg  [1:0]  fail_h0;
  reg  [1:0]  fail_h1;
  reg  [1:0]  fail_filt;
  reg  [3:0]  evt_prev;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         hstate;
  reg         soft_ack_pulse;
  reg  [7:0]  next_local_int_out;
  reg  [7:1]  lvl_on;
  reg  [7:1]  soft_on;
  reg  [2:0]  pick_level;
  reg  [31:0] rd_word;
  reg         rd_ok;
  reg  [15:0] ls_set;
  reg  [11:0] vs_set;
  reg  [15:0] ls_clr;
  reg  [11:0] vs_clr;
  reg  [7:0]  oh_tmp;
  integer     i;
  integer     j;

  wire [47:0] lmap_all = {local_side_map_high, local_side_map_low};
  wire [35:0] vmap_all = {vme_side_map_high, vme_side_map_low};
  wire [3:0]  evt_now  = {bus_ownership_granted, dma_event, local_fault_event,
                          vme_fault_event};
  wire [3:0]  evt_rise = evt_now & ~evt_prev;
  // Byte lanes of the held write; registers keep the lanes that are not strobed.
  wire [31:0] wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wr_new   = w_data & wmask;
  wire        wr_go    = aw_held && w_held && !s_axi_bvalid;
  wire        rd_go    = s_axi_arvalid && !s_axi_rvalid;
  wire        wr_ctl   = wr_go && (aw_addr == `OFF_CONTROL) && w_strb[0];
  wire        iack_ours = iack_strobe && iackin_asserted &&
                          (iack_level != 3'd0) && lvl_on[iack_level];
  wire        cap_pulse = (hstate == `ST_ACK) && iack_master_done;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign bus_ownership_request = own_req;

  // Line, level and fail inputs pass two flip-flops; fail lines then need three equal samples.
  // sync and filter
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      line_s1   <= 8'h00;
      line_s2   <= 8'h00;
      irq_s1    <= 7'h00;
      irq_s2    <= 7'h00;
      fail_s1   <= 2'h0;
      fail_s2   <= 2'h0;
      fail_h0   <= 2'h0;
      fail_h1   <= 2'h0;
      fail_filt <= 2'h0;
      evt_prev  <= 4'h0;
    end
    else
    begin
      line_s1   <= local_int_line;
      line_s2   <= line_s1;
      irq_s1    <= ~vme_irq_in_n;
      irq_s2    <= irq_s1;
      fail_s1   <= {~sysfail_n, ~acfail_n};
      fail_s2   <= fail_s1;
      fail_h0   <= fail_s2;
      fail_h1   <= fail_h0;
      fail_filt <= (fail_s2 & fail_h0 & fail_h1) |
                   (fail_filt & (fail_s2 | fail_h0 | fail_h1));
      evt_prev  <= evt_now;
    end
  end

  // Set and clear terms of both status registers.
  always @*
  begin
    ls_set = 16'h0000;
    ls_set[`LSRC_ACFAIL]  = fail_filt[0];
    ls_set[`LSRC_SYSFAIL] = fail_filt[1];
    ls_set[`LSRC_SOFT]        = wr_ctl && w_data[`CTL_LOCAL_SOFT];
    ls_set[`LSRC_SOFT_ACK]    = soft_ack_pulse;
    ls_set[`LSRC_VME_FAULT]   = evt_rise[0];
    ls_set[`LSRC_LOCAL_FAULT] = evt_rise[1];
    ls_set[`LSRC_DMA]         = evt_rise[2];
    ls_set[`LSRC_OWNERSHIP]   = evt_rise[3] && own_req;
    for (i = 1; i < 8; i = i + 1)
      ls_set[`LSRC_LEVEL_BASE + i - 1] = cap_pulse && (iack_master_level == i);
    // vme status sets on any firing
    vs_set = {wr_ctl && w_data[`CTL_VME_SOFT], evt_rise[1], evt_rise[0],
              evt_rise[2], line_s2};
    ls_clr = 16'h0000;
    vs_clr = 12'h000;
    if (wr_go && aw_addr == `OFF_LOCAL_STATUS)
      ls_clr = wr_new[15:0];
    if (wr_go && aw_addr == `OFF_VME_STATUS)
      vs_clr = wr_new[11:0];
    if (iack_ours && soft_on[iack_level])
      vs_clr[`VSRC_SOFT] = 1'b1;
  end

  // Route pending enabled sources to local outputs and vme levels.
  // separate source sets
  always @*
  begin
    next_local_int_out = 8'h00;
    lvl_on  = 7'h00;
    soft_on = 7'h00;
    oh_tmp  = 8'h00;
    for (j = 0; j < 15; j = j + 1)
      if (local_side_enable[j] && local_side_status[j])
        next_local_int_out = next_local_int_out | onehot3(lmap_all[3*j +: 3]);
    for (j = 0; j < 12; j = j + 1)
      if (vme_side_enable[j] && vme_side_status[j])
      begin
        oh_tmp = onehot3(vmap_all[3*j +: 3]);
        lvl_on = lvl_on | oh_tmp[7:1];
      end
    oh_tmp = onehot3(vmap_all[3*`VSRC_SOFT +: 3]);
    if (vme_side_enable[`VSRC_SOFT] && vme_side_status[`VSRC_SOFT])
      soft_on = oh_tmp[7:1];
    pick_level = 3'd0;
    for (j = 1; j < 8; j = j + 1)
      if (irq_s2[j] && local_side_enable[`LSRC_LEVEL_BASE + j - 1] &&
          !local_side_status[`LSRC_LEVEL_BASE + j - 1])
        pick_level = j[2:0];
  end

  // Status registers, outputs and the IACK answer.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      local_side_status <= 16'h0000;
      vme_side_status   <= 12'h000;
      local_int_out     <= 8'h00;
      vme_irq_out_n     <= 7'h7f;
      iack_hit          <= 1'b0;
      iack_pass         <= 1'b0;
      iack_vector       <= 8'h00;
      soft_ack_pulse    <= 1'b0;
    end
    else
    begin
      local_side_status <= (local_side_status & ~ls_clr) | ls_set;
      vme_side_status   <= (vme_side_status & ~vs_clr) | vs_set;
      local_int_out     <= next_local_int_out;
      vme_irq_out_n     <= ~lvl_on;
      iack_hit          <= iack_ours;
      iack_pass         <= iack_strobe && iackin_asserted && !iack_ours;
      soft_ack_pulse    <= iack_ours && soft_on[iack_level];
      if (iack_ours)
      begin
        iack_vector <= {vector_value_reg, ~soft_on[iack_level]};
      end
    end
  end

  // IACK handler: request the master, hold until the vector arrives.
  // run IACK and capture
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      hstate            <= `ST_IDLE;
      iack_master_req   <= 1'b0;
      iack_master_level <= 3'd0;
    end
    else
    begin
      case (hstate)
        `ST_IDLE:
        begin
          if (pick_level != 3'd0)
          begin
            hstate            <= `ST_ACK;
            iack_master_req   <= 1'b1;
            iack_master_level <= pick_level;
          end
        end
        `ST_ACK:
        begin
          if (iack_master_done)
          begin
            hstate          <= `ST_IDLE;
            iack_master_req <= 1'b0;
          end
        end
        default:
        begin
          hstate          <= `ST_IDLE;
          iack_master_req <= 1'b0;
        end
      endcase
    end
  end

  // Captured vector per level with its error flag.
  always @(posedge sys_clk)
  begin
    if (cap_pulse)
      cap_vec[iack_master_level] <= {iack_master_err, iack_master_vector};
  end

  // AXI write side: address and data taken in any order, then one response.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        // Upper address bits park the address on an unmapped word.
        aw_addr <= (|s_axi_awaddr[31:8]) ? 8'hff : {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= `OFF_CONTROL) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Writable configuration registers.
  // per-source enables
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      local_side_enable   <= `RST_ENABLE;
      local_side_map_low  <= `RST_MAP;
      local_side_map_high <= `RST_MAP;
      vme_side_enable     <= 12'h000;
      vme_side_map_low    <= `RST_MAP;
      vme_side_map_high   <= 12'h000;
      vector_value_reg    <= `RST_VECTOR;
      own_req             <= 1'b0;
    end
    else if (wr_go)
    begin
      case (aw_addr)
        `OFF_LOCAL_ENABLE:
          local_side_enable <= (local_side_enable & ~wmask[15:0]) | wr_new[15:0];
        `OFF_LOCAL_MAP_LOW:
          local_side_map_low <= (local_side_map_low & ~wmask[23:0]) | wr_new[23:0];
        `OFF_LOCAL_MAP_HIGH:
          local_side_map_high <= (local_side_map_high & ~wmask[23:0]) | wr_new[23:0];
        `OFF_VME_ENABLE:
          vme_side_enable <= (vme_side_enable & ~wmask[11:0]) | wr_new[11:0];
        `OFF_VME_MAP_LOW:
          vme_side_map_low <= (vme_side_map_low & ~wmask[23:0]) | wr_new[23:0];
        `OFF_VME_MAP_HIGH:
          vme_side_map_high <= (vme_side_map_high & ~wmask[11:0]) | wr_new[11:0];
        `OFF_VECTOR_VALUE:
          if (w_strb[0])
            vector_value_reg <= w_data[7:1];
        `OFF_CONTROL:
          if (w_strb[0])
            own_req <= w_data[`CTL_OWN_REQ];
        default:
          own_req <= own_req;
      endcase
    end
  end

  // Read decode; unmapped addresses answer SLVERR with zero data.
  always @*
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFF_LOCAL_ENABLE:   rd_word = {16'h0, local_side_enable};
      `OFF_LOCAL_STATUS:   rd_word = {16'h0, local_side_status};
      `OFF_LOCAL_MAP_LOW:  rd_word = {8'h0, local_side_map_low};
      `OFF_LOCAL_MAP_HIGH: rd_word = {8'h0, local_side_map_high};
      `OFF_VME_ENABLE:     rd_word = {20'h0, vme_side_enable};
      `OFF_VME_STATUS:     rd_word = {20'h0, vme_side_status};
      `OFF_VME_MAP_LOW:    rd_word = {8'h0, vme_side_map_low};
      `OFF_VME_MAP_HIGH:   rd_word = {20'h0, vme_side_map_high};
      `OFF_VECTOR_VALUE:   rd_word = {24'h0, vector_value_reg, 1'b0};
      `OFF_CONTROL:        rd_word = {29'h0, own_req, 2'b00};
      default:
      begin
        if (s_axi_araddr[7:0] >= `OFF_CAPTURE_FIRST &&
            s_axi_araddr[7:0] <= `OFF_CAPTURE_LAST)
          rd_word = {23'h0, cap_vec[s_axi_araddr[4:2] - 3'd1]};
        else
          rd_ok = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:8] != 24'h0)
      rd_ok = 1'b0;
    if (!rd_ok)
      rd_word = 32'h0;
  end

  // AXI read side: answer one cycle after the address is taken.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ### verification/vme_handler_model.sv
`timescale 1ns/1ns
module vme_handler_model (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [7:1] vme_irq_out_n,
  input  wire       iack_go,
  input  wire [2:0] force_lvl,
  input  wire       slow,
  output reg        iack_strobe,
  output reg  [2:0] iack_level,
  output reg        iackin_asserted,
  input  wire       iack_master_req,
  input  wire [2:0] iack_master_level,
  output reg        iack_master_done,
  output reg  [7:0] iack_master_vector,
  output reg        iack_master_err
);
  reg       go_d;
  reg [3:0] wait_cnt;
  reg [2:0] lvl;
  integer   i;
  // Picks the highest level that is asserted on the bus.
  always @*
  begin
    lvl = 3'h0;
    for (i = 1; i < 8; i = i + 1)
      if (!vme_irq_out_n[i])
        lvl = i[2:0];
  end
  // Runs one acknowledge cycle per request; the level lines toggle when idle.
  // handler acknowledges level
  always @(posedge sys_clk)
  begin
    go_d <= iack_go;
    iack_strobe <= iack_go && !go_d;
    iackin_asserted <= iack_go && !go_d;
    iack_level <= (iack_go && !go_d) ? ((force_lvl != 3'h0) ? force_lvl : lvl) : ~iack_level;
  end
  // Answers a vector fetch after a short or long delay; data toggles when idle.
  always @(posedge sys_clk)
  begin
    iack_master_done <= 1'b0;
    iack_master_err <= 1'b0;
    iack_master_vector <= rst ? 8'h00 : ~iack_master_vector;
    if (rst || !iack_master_req || iack_master_done)
      wait_cnt <= slow ? 4'd9 : 4'd1;
    else if (wait_cnt != 4'd0)
      wait_cnt <= wait_cnt - 4'd1;
    else
    begin
      iack_master_done <= 1'b1;
      iack_master_vector <= {5'h15, iack_master_level};
    end
  end
endmodule

// ### verification/vme_int_props.sv
`timescale 1ns/1ns
module vme_int_props (
  input wire        sys_clk,
  input wire        rst,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        iack_strobe,
  input wire        iackin_asserted,
  input wire        iack_hit,
  input wire        iack_pass,
  input wire        iack_master_req,
  input wire [2:0]  iack_master_level,
  input wire        iack_master_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // An acknowledge cycle that reaches us through the daisy chain.
  sequence s_chain_iack;
    iack_strobe && iackin_asserted;
  endsequence
  // A vector fetch that is still waiting for its answer.
  sequence s_fetch_wait;
    iack_master_req && !iack_master_done;
  endsequence
  a_chain_answered: assert property (s_chain_iack |=> iack_hit != iack_pass)
    else $error("Chain acknowledge got no single answer.");
  a_answer_cause: assert property ((iack_hit || iack_pass) |-> $past(iack_strobe && iackin_asserted))
    else $error("Acknowledge answer without a chained strobe.");
  a_fetch_held: assert property (s_fetch_wait |=> iack_master_req)
    else $error("Vector fetch dropped before its answer.");
  a_fetch_level_stable: assert property (s_fetch_wait |=> $stable(iack_master_level))
    else $error("Fetch level moved during a fetch.");
  a_fetch_release: assert property (iack_master_req && iack_master_done |=> !iack_master_req)
    else $error("Vector fetch not released after its answer.");
  a_fetch_level_valid: assert property (iack_master_req |-> iack_master_level != 3'h0)
    else $error("Vector fetch on level zero.");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response withdrawn early.");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data changed before acceptance.");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Second read answered without a request.");
endmodule

bind vme_pci_interrupt_channel vme_int_props u_props (.sys_clk, .rst, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .iack_strobe, .iackin_asserted,
  .iack_hit, .iack_pass, .iack_master_req, .iack_master_level, .iack_master_done);

// ### verification/vme_pci_interrupt_channel_test.sv
`timescale 1ns/1ns
`include "vme_int_regs.vh"
module vme_pci_interrupt_channel_test;
  reg         sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready, acfail_n, sysfail_n, dma_event, vme_fault_event;
  reg         local_fault_event, bus_ownership_granted, iack_go, slow;
  reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  reg  [3:0]  s_axi_wstrb;
  reg  [7:0]  local_int_line;
  reg  [7:1]  vme_irq_in_n;
  reg  [2:0]  force_lvl;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        bus_ownership_request, iack_strobe, iackin_asserted, iack_hit, iack_pass;
  wire        iack_master_req, iack_master_done, iack_master_err;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  local_int_out, iack_vector, iack_master_vector;
  wire [7:1]  vme_irq_out_n;
  wire [2:0]  iack_level, iack_master_level;
  integer     fails, checks_done;

  vme_pci_interrupt_channel dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .local_int_line, .vme_irq_in_n, .acfail_n, .sysfail_n,
    .dma_event, .vme_fault_event, .local_fault_event, .bus_ownership_granted,
    .bus_ownership_request, .local_int_out, .vme_irq_out_n, .iack_strobe, .iack_level,
    .iackin_asserted, .iack_hit, .iack_pass, .iack_vector, .iack_master_req,
    .iack_master_level, .iack_master_done, .iack_master_vector, .iack_master_err);
  vme_handler_model peer (.sys_clk, .rst, .vme_irq_out_n, .iack_go, .force_lvl, .slow,
    .iack_strobe, .iack_level, .iackin_asserted, .iack_master_req, .iack_master_level,
    .iack_master_done, .iack_master_vector, .iack_master_err);

  // Clock at 125 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task tk(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Bus write: address and data offered together, each released when taken.
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg     aw_ok, w_ok;
    integer n;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
        @(posedge sys_clk);
        n = n + 1;
        if (!aw_ok && s_axi_awready)
        begin
          aw_ok = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_ok && s_axi_wready)
        begin
          w_ok = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
        // A late bready makes the response wait one cycle.
        if (n == 3)
          s_axi_bready <= 1'b1;
      end
      while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask

  // Bus read with expected data and response.
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    begin
      n = 0;
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      do
      begin
        @(posedge sys_clk);
        n = n + 1;
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (n == 2)
          s_axi_rready <= 1'b1;
      end
      while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask

  // Has the partner run one acknowledge cycle and checks the answer.
  task iack(input [2:0] lvl, input hit, input [7:0] vec);
    integer n;
    begin
      force_lvl <= lvl;
      iack_go <= 1'b1;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n = n + 1;
      end
      while (!(iack_hit || iack_pass) && n < 20);
      iack_go <= 1'b0;
      chk({iack_hit, iack_pass}, {hit, !hit});
      if (hit)
        chk(iack_vector, vec);
      tk(1);
    end
  endtask

  task print_verdict;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Cuts a hang short.
  initial
  begin
    #(8 * 30000);
    fails = fails + 1;
    print_verdict;
  end

  // Main sequence of bus calls and pin events.
  initial
  begin
    {fails, checks_done} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, local_int_line, force_lvl} = 0;
    {dma_event, vme_fault_event, local_fault_event, bus_ownership_granted, iack_go} = 5'h00;
    {acfail_n, sysfail_n, vme_irq_in_n, slow, s_axi_wstrb} = {2'h3, 7'h7f, 1'b0, 4'hf};
    rst = 1'b1;
    tk(12);
    rst <= 1'b0;
    tk(4);
    rd(`OFF_LOCAL_ENABLE, 32'h0, `RESP_OKAY);
    rd(`OFF_VME_MAP_LOW, 32'h0, `RESP_OKAY);
    chk(vme_irq_out_n, 7'h7f);
    rd(8'h44, 32'h0, `RESP_SLVERR);
    wr(`OFF_CAPTURE_FIRST, 32'hff, `RESP_SLVERR);
    wr(`OFF_LOCAL_MAP_LOW, 32'h140000, `RESP_OKAY);
    wr(`OFF_LOCAL_ENABLE, 32'h40, `RESP_OKAY);
    dma_event <= 1'b1;
    tk(4);
    chk(local_int_out, 8'h20);
    tk(20);
    chk(local_int_out, 8'h20);
    rd(`OFF_LOCAL_STATUS, 32'h40, `RESP_OKAY);
    wr(`OFF_LOCAL_STATUS, 32'h40, `RESP_OKAY);
    tk(3);
    chk(local_int_out, 8'h00);
    dma_event <= 1'b0;
    wr(`OFF_CONTROL, 32'h5, `RESP_OKAY);
    chk(bus_ownership_request, 1'b1);
    {vme_fault_event, local_fault_event, bus_ownership_granted, sysfail_n} <= 4'he;
    tk(1);
    {vme_fault_event, local_fault_event, bus_ownership_granted} <= 3'h0;
    tk(8);
    sysfail_n <= 1'b1;
    tk(8);
    rd(`OFF_LOCAL_STATUS, 32'hb6, `RESP_OKAY);
    chk(local_int_out, 8'h00);
    wr(`OFF_LOCAL_STATUS, 32'hb6, `RESP_OKAY);
    rd(`OFF_LOCAL_STATUS, 32'h0, `RESP_OKAY);
    wr(`OFF_LOCAL_MAP_LOW, 32'h1, `RESP_OKAY);
    wr(`OFF_LOCAL_ENABLE, 32'h1, `RESP_OKAY);
    acfail_n <= 1'b0;
    tk(2);
    acfail_n <= 1'b1;
    tk(6);
    chk(local_int_out, 8'h00);
    acfail_n <= 1'b0;
    tk(8);
    chk(local_int_out, 8'h02);
    wr(`OFF_LOCAL_STATUS, 32'h1, `RESP_OKAY);
    tk(3);
    chk(local_int_out, 8'h02);
    acfail_n <= 1'b1;
    tk(8);
    chk(local_int_out, 8'h02);
    wr(`OFF_LOCAL_STATUS, 32'h1, `RESP_OKAY);
    tk(3);
    chk(local_int_out, 8'h00);
    wr(`OFF_VECTOR_VALUE, 32'h5a, `RESP_OKAY);
    wr(`OFF_VME_MAP_LOW, 32'h800, `RESP_OKAY);
    wr(`OFF_VME_MAP_HIGH, 32'h800, `RESP_OKAY);
    wr(`OFF_VME_ENABLE, 32'h80c, `RESP_OKAY);
    local_int_line <= 8'h04;
    tk(6);
    chk(vme_irq_out_n, 7'h7f);
    rd(`OFF_VME_STATUS, 32'h704, `RESP_OKAY);
    wr(`OFF_CONTROL, 32'h2, `RESP_OKAY);
    tk(3);
    chk(vme_irq_out_n, 7'h77);
    iack(3'd4, 1'b1, 8'h5a);
    tk(3);
    chk(vme_irq_out_n, 7'h7f);
    rd(`OFF_LOCAL_STATUS, 32'h8, `RESP_OKAY);
    local_int_line <= 8'h0c;
    tk(6);
    chk(vme_irq_out_n, 7'h77);
    chk(local_int_out, 8'h00);
    iack(3'd2, 1'b0, 8'h00);
    iack(3'd4, 1'b1, 8'h5b);
    tk(3);
    chk(vme_irq_out_n, 7'h77);
    wr(`OFF_CONTROL, 32'h2, `RESP_OKAY);
    tk(3);
    iack(3'd4, 1'b1, 8'h5a);
    local_int_line <= 8'h00;
    tk(3);
    chk(vme_irq_out_n, 7'h77);
    wr(`OFF_VME_STATUS, 32'hc, `RESP_OKAY);
    tk(3);
    chk(vme_irq_out_n, 7'h7f);
    wr(`OFF_LOCAL_MAP_HIGH, 32'h38000, `RESP_OKAY);
    wr(`OFF_LOCAL_ENABLE, 32'h2100, `RESP_OKAY);
    slow <= 1'b1;
    vme_irq_in_n <= 7'h5e;
    tk(6);
    chk(local_int_out, 8'h00);
    tk(60);
    chk(local_int_out, 8'h81);
    rd(8'h3c, 32'hae, `RESP_OKAY);
    rd(8'h28, 32'ha9, `RESP_OKAY);
    rd(`OFF_LOCAL_STATUS, 32'h2108, `RESP_OKAY);
    vme_irq_in_n <= 7'h7f;
    tk(6);
    wr(`OFF_LOCAL_STATUS, 32'h2100, `RESP_OKAY);
    tk(20);
    chk(local_int_out, 8'h00);
    print_verdict;
  end
endmodule
